// [cvpid_pkg.sv]
package cvpid_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int MS_PER_S = 1000;
   localparam int TICK_MS = 1;
   localparam int CLK_PER_MS = CLK_HZ / MS_PER_S * TICK_MS;
   localparam int SAVE_SPACING_S = 10;
   localparam int SAVE_SPACING_CYCLES = SAVE_SPACING_S * CLK_HZ;

   // ----------------------------------------------------------------
   // scaling
   // ----------------------------------------------------------------
   // percentages are held in 0.01 % steps
   localparam int PCT_FULL = 10000;
   localparam int GAIN_FRAC = 8;
   localparam int SUM_LIMIT = 8388607;
   localparam logic [3:0] CONST_TYPE = 4'h3;

   // ----------------------------------------------------------------
   // register map (byte offsets)
   // ----------------------------------------------------------------
   localparam logic [7:0] CV_CFG_OFS = 8'h00;
   localparam logic [7:0] CV_VALUE_OFS = 8'h04;
   localparam logic [7:0] CV_STAT_OFS = 8'h08;
   localparam logic [7:0] PID_CFG_OFS = 8'h0C;
   localparam logic [7:0] PID_PERIOD_OFS = 8'h10;
   localparam logic [7:0] PID_TOL_OFS = 8'h14;
   localparam logic [7:0] PID_GAIN_OFS = 8'h18;
   localparam logic [7:0] PID_INTEG_OFS = 8'h1C;
   localparam logic [7:0] PID_DERIV_OFS = 8'h20;
   localparam logic [7:0] PID_OUT_OFS = 8'h24;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int TRIG_SEL_LSB = 0;
   localparam int THR_SEL_LSB = 8;
   localparam int DATA_SEL_LSB = 16;
   localparam int OP_LSB = 24;
   localparam int TGT_SEL_LSB = 0;
   localparam int FB_SEL_LSB = 8;
   localparam int PROF_LSB = 16;
   localparam int EN_BIT = 18;
   localparam int OUT_SEL_LSB = 20;
   localparam int HI_HALF_LSB = 16;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] CV_CFG_RST = 32'h0000_0000;
   localparam logic [15:0] CV_VALUE_RST = 16'h0000;
   localparam logic [31:0] PID_CFG_RST = 32'h0000_0000;
   localparam logic [15:0] PID_PERIOD_RST = 16'h000A;
   localparam logic [15:0] PID_TOL_RST = 16'h0000;
   localparam logic [15:0] PID_GAIN_RST = 16'h0100;
   localparam logic [31:0] PID_INTEG_RST = 32'h0000_0000;
   localparam logic [31:0] PID_DERIV_RST = 32'h0000_0000;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {PROF_SINGLE, PROF_SETPOINT, PROF_OVER, PROF_BELOW} profile_e;
   typedef enum logic [2:0] {OP_EQ, OP_NE, OP_GT, OP_GE, OP_LT, OP_LE, OP_SUB} cmp_op_e;

   typedef struct packed {
      logic signed [15:0] val;
      logic signed [15:0] min;
      logic signed [15:0] max;
   } src_s;

endpackage

// [cvpid_div.sv]
`timescale 1ns/1ps
`default_nettype none

// unsigned restoring divider, one quotient bit per clock
module cvpid_div #(
   parameter int W = 48
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic start_i,
   input wire logic [W-1:0] num_i,
   input wire logic [W-1:0] den_i,
   output logic done_o,
   output logic [W-1:0] quot_o
);

   localparam int CW = $clog2(W + 1);

   if (W < 2) begin : g_bad_width
      $error("cvpid_div: W must be at least 2");
   end

   logic [W-1:0] q_r;
   logic [W-1:0] d_r;
   logic [W:0] r_r;
   logic [CW-1:0] cnt_r;
   logic busy_r;
   logic done_r;

   wire [W:0] r_sh = {r_r[W-1:0], q_r[W-1]};
   wire ge = r_sh >= {1'b0, d_r};
   wire [W:0] r_sub = r_sh - {1'b0, d_r};

   // a zero divisor yields all ones; callers filter that case
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q_r <= '0;
         d_r <= '0;
         r_r <= '0;
         cnt_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (start_i) begin
            q_r <= num_i;
            d_r <= den_i;
            r_r <= '0;
            cnt_r <= CW'(W);
            busy_r <= 1'b1;
         end else if (busy_r) begin
            q_r <= {q_r[W-2:0], ge};
            r_r <= ge ? r_sub : r_sh;
            cnt_r <= cnt_r - 1'b1;
            if (cnt_r == CW'(1)) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end
         end
      end
   end

   assign done_o = done_r;
   assign quot_o = q_r;

endmodule

`default_nettype wire

// [cvpid_core.sv]
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - compare trigger against threshold with chosen operator
// - true comparison loads variable and saves it
// - one save per true phase, rearm on false
// - at least ten seconds between two saves
// - variable readable and writable by software
// - outputs set to pid follow pid command
// - target and feedback chosen by type and number
// - one pid step per loop period
// - four response profiles, codes zero to three
// - single output scales to percent, plus minus
// - setpoint profile forces constant target, zero up
// - setpoint target uses feedback minimum and maximum
// - over and below profiles limit zero to full
// - error inside tolerance band becomes zero
// - output is p, i and d terms summed
// - gains derived from period, factors and times
module cvpid_core #(
   parameter int NUM_TYPES = 4,
   parameter int NUM_PER_TYPE = 4,
   parameter int NUM_OUTPUTS = 2,
   parameter int CLK_PER_MS = cvpid_pkg::CLK_PER_MS,
   parameter int SAVE_SPACING_CYCLES = cvpid_pkg::SAVE_SPACING_CYCLES
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire cvpid_pkg::src_s [NUM_TYPES*NUM_PER_TYPE-1:0] src_i,
   input wire logic [NUM_OUTPUTS-1:0][15:0] manual_cmd_i,
   output logic [NUM_OUTPUTS-1:0][15:0] out_cmd_o,
   output logic nv_save_o,
   output logic [15:0] nv_data_o,
   output logic [15:0] pid_out_o
);

   localparam int NSRC = NUM_TYPES * NUM_PER_TYPE;
   localparam int DW = 48;

   if (NUM_TYPES < 1 || NUM_TYPES > 16 || NUM_PER_TYPE < 1 || NUM_PER_TYPE > 16 ||
       NUM_OUTPUTS < 1 || NUM_OUTPUTS > 4 || CLK_PER_MS < 1 || SAVE_SPACING_CYCLES < 1) begin : g_bad_cfg
      $error("cvpid_core: parameter out of range");
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic cvpid_pkg::src_s pick(input logic [7:0] sel, input cvpid_pkg::src_s [NSRC-1:0] s);
      int idx;
      idx = int'(sel[7:4]) * NUM_PER_TYPE + int'(sel[3:0]);
      pick = '0;
      if (int'(sel[7:4]) < NUM_TYPES && int'(sel[3:0]) < NUM_PER_TYPE) begin
         pick = s[idx];
      end
   endfunction

   // numerator of the percent scaling, value clamped into its range
   function automatic logic [DW-1:0] pct_num(input cvpid_pkg::src_s s);
      logic signed [16:0] v;
      v = 17'(s.val);
      if (s.val < s.min) v = 17'(s.min);
      if (s.val > s.max) v = 17'(s.max);
      pct_num = DW'(v - 17'(s.min)) * DW'(cvpid_pkg::PCT_FULL);
   endfunction

   function automatic logic [DW-1:0] span(input cvpid_pkg::src_s s);
      span = (s.max > s.min) ? DW'(17'(s.max) - 17'(s.min)) : '0;
   endfunction

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   logic [31:0] cv_cfg_r;
   logic [15:0] cv_value_r;
   logic [31:0] pid_cfg_r;
   logic [15:0] period_r;
   logic [15:0] tol_r;
   logic [15:0] gain_r;
   logic [31:0] integ_r;
   logic [31:0] deriv_r;
   logic [31:0] prdata_r;
   logic signed [15:0] pid_out_r;
   logic armed_r;
   logic [31:0] holdoff_r;
   logic cmp_true;

   wire setup = psel_i & ~penable_i;
   wire wr_en = psel_i & penable_i & pwrite_i;
   wire hit_cv_cfg = paddr_i == cvpid_pkg::CV_CFG_OFS;
   wire hit_cv_value = paddr_i == cvpid_pkg::CV_VALUE_OFS;
   wire hit_cv_stat = paddr_i == cvpid_pkg::CV_STAT_OFS;
   wire hit_pid_cfg = paddr_i == cvpid_pkg::PID_CFG_OFS;
   wire hit_period = paddr_i == cvpid_pkg::PID_PERIOD_OFS;
   wire hit_tol = paddr_i == cvpid_pkg::PID_TOL_OFS;
   wire hit_gain = paddr_i == cvpid_pkg::PID_GAIN_OFS;
   wire hit_integ = paddr_i == cvpid_pkg::PID_INTEG_OFS;
   wire hit_deriv = paddr_i == cvpid_pkg::PID_DERIV_OFS;
   wire hit_out = paddr_i == cvpid_pkg::PID_OUT_OFS;
   wire hit_any = hit_cv_cfg | hit_cv_value | hit_cv_stat | hit_pid_cfg | hit_period |
                  hit_tol | hit_gain | hit_integ | hit_deriv | hit_out;

   // pid settings
   wire cvpid_pkg::profile_e profile = cvpid_pkg::profile_e'(pid_cfg_r[cvpid_pkg::PROF_LSB +: 2]);
   wire is_setpoint = profile == cvpid_pkg::PROF_SETPOINT;
   wire pid_en = pid_cfg_r[cvpid_pkg::EN_BIT];
   wire [7:0] tgt_sel_raw = pid_cfg_r[cvpid_pkg::TGT_SEL_LSB +: 8];
   // the target type is locked to the constant block in setpoint mode
   wire [7:0] tgt_sel = is_setpoint ? {cvpid_pkg::CONST_TYPE, tgt_sel_raw[3:0]} : tgt_sel_raw;
   wire [31:0] pid_cfg_rd = {pid_cfg_r[31:8], tgt_sel};
   wire [31:0] cv_stat_rd = {30'h0, cmp_true, armed_r};

   assign prdata_o = prdata_r;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit_any;

   // read data is latched in the setup cycle so the access phase needs no wait
   wire [31:0] rd_mux = hit_cv_cfg ? cv_cfg_r :
                        hit_cv_value ? {16'h0, cv_value_r} :
                        hit_cv_stat ? cv_stat_rd :
                        hit_pid_cfg ? pid_cfg_rd :
                        hit_period ? {16'h0, period_r} :
                        hit_tol ? {16'h0, tol_r} :
                        hit_gain ? {16'h0, gain_r} :
                        hit_integ ? integ_r :
                        hit_deriv ? deriv_r :
                        hit_out ? {{16{pid_out_r[15]}}, pid_out_r} : 32'h0000_0000;

   // ----------------------------------------------------------------
   // control variable
   // ----------------------------------------------------------------
   wire cvpid_pkg::src_s trig = pick(cv_cfg_r[cvpid_pkg::TRIG_SEL_LSB +: 8], src_i);
   wire cvpid_pkg::src_s thr = pick(cv_cfg_r[cvpid_pkg::THR_SEL_LSB +: 8], src_i);
   wire cvpid_pkg::src_s dsrc = pick(cv_cfg_r[cvpid_pkg::DATA_SEL_LSB +: 8], src_i);
   wire cvpid_pkg::cmp_op_e op = cvpid_pkg::cmp_op_e'(cv_cfg_r[cvpid_pkg::OP_LSB +: 3]);
   wire signed [16:0] cmp_diff = 17'(trig.val) - 17'(thr.val);

   always_comb begin
      case (op)
         cvpid_pkg::OP_EQ: cmp_true = cmp_diff == 17'sh0;
         cvpid_pkg::OP_NE: cmp_true = cmp_diff != 17'sh0;
         cvpid_pkg::OP_GT: cmp_true = cmp_diff > 17'sh0;
         cvpid_pkg::OP_GE: cmp_true = cmp_diff >= 17'sh0;
         cvpid_pkg::OP_LT: cmp_true = cmp_diff < 17'sh0;
         cvpid_pkg::OP_LE: cmp_true = cmp_diff <= 17'sh0;
         cvpid_pkg::OP_SUB: cmp_true = cmp_diff > 17'sh0;
         default: cmp_true = 1'b0;
      endcase
   end

   // a true phase that starts during the spacing waits and saves once it ends
   wire save = cmp_true & armed_r & (holdoff_r == 32'h0000_0000);
   logic nv_save_r;
   logic [15:0] nv_data_r;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         armed_r <= 1'b1;
         holdoff_r <= '0;
         nv_save_r <= 1'b0;
         nv_data_r <= '0;
      end else begin
         nv_save_r <= save;
         if (save) begin
            armed_r <= 1'b0;
            holdoff_r <= 32'(SAVE_SPACING_CYCLES - 1);
            nv_data_r <= dsrc.val;
         end else begin
            if (!cmp_true) armed_r <= 1'b1;
            if (holdoff_r != 32'h0000_0000) holdoff_r <= holdoff_r - 32'h0000_0001;
         end
      end
   end

   assign nv_save_o = nv_save_r;
   assign nv_data_o = nv_data_r;

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cv_cfg_r <= cvpid_pkg::CV_CFG_RST;
         cv_value_r <= cvpid_pkg::CV_VALUE_RST;
         pid_cfg_r <= cvpid_pkg::PID_CFG_RST;
         period_r <= cvpid_pkg::PID_PERIOD_RST;
         tol_r <= cvpid_pkg::PID_TOL_RST;
         gain_r <= cvpid_pkg::PID_GAIN_RST;
         integ_r <= cvpid_pkg::PID_INTEG_RST;
         deriv_r <= cvpid_pkg::PID_DERIV_RST;
         prdata_r <= '0;
      end else begin
         if (setup) prdata_r <= rd_mux;
         // a hardware save beats a software write in the same cycle
         if (save) cv_value_r <= dsrc.val;
         else if (wr_en && hit_cv_value) cv_value_r <= pwdata_i[15:0];
         if (wr_en && hit_cv_cfg) cv_cfg_r <= pwdata_i;
         if (wr_en && hit_pid_cfg) pid_cfg_r <= pwdata_i;
         if (wr_en && hit_period) period_r <= pwdata_i[15:0];
         if (wr_en && hit_tol) tol_r <= pwdata_i[15:0];
         if (wr_en && hit_gain) gain_r <= pwdata_i[15:0];
         if (wr_en && hit_integ) integ_r <= pwdata_i;
         if (wr_en && hit_deriv) deriv_r <= pwdata_i;
      end
   end

   // ----------------------------------------------------------------
   // loop timing
   // ----------------------------------------------------------------
   logic [31:0] ms_cnt_r;
   logic [15:0] loop_cnt_r;
   wire ms_tick = ms_cnt_r == 32'(CLK_PER_MS - 1);
   // a zero period runs the loop every millisecond
   wire [15:0] period_eff = (period_r == 16'h0000) ? 16'h0001 : period_r;
   wire loop_tick = pid_en & ms_tick & (loop_cnt_r >= period_eff - 16'h0001);

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ms_cnt_r <= '0;
         loop_cnt_r <= '0;
      end else begin
         ms_cnt_r <= ms_tick ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
         if (!pid_en || loop_tick) loop_cnt_r <= '0;
         else if (ms_tick) loop_cnt_r <= loop_cnt_r + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // pid step sequencer
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {P_IDLE, P_GAIN_I, P_GAIN_D, P_SCALE_T, P_SCALE_F, P_CALC} pstate_e;
   pstate_e state_r;
   pstate_e state_nxt;
   logic div_start;
   logic [DW-1:0] div_num;
   logic [DW-1:0] div_den;
   logic div_done;
   logic [DW-1:0] div_q;

   wire cvpid_pkg::src_s fb = pick(pid_cfg_r[cvpid_pkg::FB_SEL_LSB +: 8], src_i);
   wire cvpid_pkg::src_s tgt_raw = pick(tgt_sel, src_i);
   wire cvpid_pkg::src_s tgt = is_setpoint ? cvpid_pkg::src_s'{val: tgt_raw.val, min: fb.min, max: fb.max} : tgt_raw;
   wire [15:0] ki = integ_r[15:0];
   wire [15:0] ti = integ_r[cvpid_pkg::HI_HALF_LSB +: 16];
   wire [15:0] kd = deriv_r[15:0];
   wire [15:0] td = deriv_r[cvpid_pkg::HI_HALF_LSB +: 16];
   // times are in ms on both sides, so the 0.001 of the step time cancels
   wire [63:0] gki = 64'(gain_r) * 64'(ki);
   wire [63:0] gkd = 64'(gain_r) * 64'(kd);
   wire [DW-1:0] num_i = DW'((gki * 64'(period_eff)) >> cvpid_pkg::GAIN_FRAC);
   wire [DW-1:0] num_d = DW'((gkd * 64'(td)) >> cvpid_pkg::GAIN_FRAC);

   always_comb begin
      state_nxt = state_r;
      div_start = 1'b0;
      div_num = '0;
      div_den = '0;
      case (state_r)
         P_IDLE: begin
            if (loop_tick) begin
               state_nxt = P_GAIN_I;
               div_start = 1'b1;
               div_num = num_i;
               div_den = DW'(ti);
            end
         end
         P_GAIN_I: begin
            if (div_done) begin
               state_nxt = P_GAIN_D;
               div_start = 1'b1;
               div_num = num_d;
               div_den = DW'(period_eff);
            end
         end
         P_GAIN_D: begin
            if (div_done) begin
               state_nxt = P_SCALE_T;
               div_start = 1'b1;
               div_num = pct_num(tgt);
               div_den = span(tgt);
            end
         end
         P_SCALE_T: begin
            if (div_done) begin
               state_nxt = P_SCALE_F;
               div_start = 1'b1;
               div_num = pct_num(fb);
               div_den = span(fb);
            end
         end
         P_SCALE_F: begin
            if (div_done) state_nxt = P_CALC;
         end
         P_CALC: state_nxt = P_IDLE;
         default: state_nxt = P_IDLE;
      endcase
   end

   cvpid_div #(
      .W(DW)
   ) u_div (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .start_i(div_start),
      .num_i(div_num),
      .den_i(div_den),
      .done_o(div_done),
      .quot_o(div_q)
   );

   // ----------------------------------------------------------------
   // pid arithmetic
   // ----------------------------------------------------------------
   logic [31:0] ig_r;
   logic [31:0] dg_r;
   logic signed [15:0] tpct_r;
   logic signed [15:0] fpct_r;
   logic signed [23:0] sum_r;
   logic signed [16:0] prev_err_r;

   wire [31:0] q_sat = (div_q > DW'(32'hFFFF_FFFF)) ? 32'hFFFF_FFFF : div_q[31:0];
   wire [15:0] q_pct = (div_q > DW'(cvpid_pkg::PCT_FULL)) ? 16'(cvpid_pkg::PCT_FULL) : div_q[15:0];
   wire signed [16:0] err_raw = (profile == cvpid_pkg::PROF_OVER) ? 17'(fpct_r) - 17'(tpct_r) :
                                17'(tpct_r) - 17'(fpct_r);
   wire signed [16:0] err_abs = err_raw[16] ? -err_raw : err_raw;
   wire signed [16:0] err = (err_abs < $signed({1'b0, tol_r})) ? 17'sh0 : err_raw;
   wire signed [24:0] sum_wide = 25'(sum_r) + 25'(err);
   wire signed [23:0] sum_nxt = (sum_wide > 25'(cvpid_pkg::SUM_LIMIT)) ? 24'(cvpid_pkg::SUM_LIMIT) :
                                (sum_wide < -25'(cvpid_pkg::SUM_LIMIT)) ? -24'(cvpid_pkg::SUM_LIMIT) :
                                sum_wide[23:0];
   wire signed [63:0] p_term = 64'($signed({1'b0, gain_r})) * 64'(err);
   wire signed [63:0] i_term = 64'($signed({1'b0, ig_r})) * 64'(sum_nxt);
   wire signed [63:0] d_term = 64'($signed({1'b0, dg_r})) * (64'(err) - 64'(prev_err_r));
   wire signed [63:0] acc = (p_term + i_term + d_term) >>> cvpid_pkg::GAIN_FRAC;
   // single output may go negative, the other profiles stop at zero
   wire signed [63:0] lo_lim = (profile == cvpid_pkg::PROF_SINGLE) ? -64'(cvpid_pkg::PCT_FULL) : 64'sh0;
   wire signed [63:0] hi_lim = 64'(cvpid_pkg::PCT_FULL);
   wire signed [63:0] out_clamp = (acc > hi_lim) ? hi_lim : (acc < lo_lim) ? lo_lim : acc;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r <= P_IDLE;
         ig_r <= '0;
         dg_r <= '0;
         tpct_r <= '0;
         fpct_r <= '0;
         sum_r <= '0;
         prev_err_r <= '0;
         pid_out_r <= '0;
      end else begin
         state_r <= state_nxt;
         if (div_done) begin
            case (state_r)
               P_GAIN_I: ig_r <= (ti == 16'h0000) ? 32'h0000_0000 : q_sat;
               P_GAIN_D: dg_r <= q_sat;
               P_SCALE_T: tpct_r <= (span(tgt) == '0) ? 16'sh0 : $signed(q_pct);
               P_SCALE_F: fpct_r <= (span(fb) == '0) ? 16'sh0 : $signed(q_pct);
               default: ;
            endcase
         end
         if (state_r == P_CALC) begin
            sum_r <= sum_nxt;
            prev_err_r <= err;
            pid_out_r <= out_clamp[15:0];
         end
      end
   end

   assign pid_out_o = pid_out_r;

   // ----------------------------------------------------------------
   // output drive selection
   // ----------------------------------------------------------------
   wire [3:0] out_sel = pid_cfg_r[cvpid_pkg::OUT_SEL_LSB +: 4];
   logic [NUM_OUTPUTS-1:0][15:0] out_cmd_r;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         out_cmd_r <= '0;
      end else begin
         for (int j = 0; j < NUM_OUTPUTS; j++) begin
            out_cmd_r[j] <= out_sel[j] ? pid_out_r : manual_cmd_i[j];
         end
      end
   end

   assign out_cmd_o = out_cmd_r;

endmodule

`default_nettype wire

// [cvpid_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// signal sources seen by the block
// ----------------------------------------
// every source spans 0..10000 so a percent equals the raw value
module cvpid_src_model (
   input wire logic clk_i,
   input wire logic set_i,
   input wire logic [3:0] idx_i,
   input wire logic [15:0] val_i,
   output var cvpid_pkg::src_s [15:0] src_o
);
   initial begin
      for (int i = 0; i < 16; i++) src_o[i] = '{16'h0000, 16'h0000, 16'h2710};
   end
   always @(posedge clk_i) begin
      if (set_i) src_o[idx_i].val <= val_i;
   end
endmodule
`default_nettype wire

// [cvpid_core_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checks
// ----------------------------------------
module cvpid_core_sva #(
   parameter int SAVE_SPACING_CYCLES = 50
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pslverr_o,
   input wire logic [1:0][15:0] manual_cmd_i,
   input wire logic [1:0][15:0] out_cmd_o,
   input wire logic nv_save_o,
   input wire logic [15:0] nv_data_o,
   input wire logic [15:0] pid_out_o
);
   logic [31:0] gap_r;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // saturating count of cycles since the last save pulse
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) gap_r <= SAVE_SPACING_CYCLES;
      else if (nv_save_o) gap_r <= 32'h1;
      else if (gap_r < SAVE_SPACING_CYCLES) gap_r <= gap_r + 32'h1;
   end
   property p_pulse; nv_save_o |=> !nv_save_o; endproperty
   a_pulse: assert property (p_pulse) else $error("save pulse too long");
   property p_gap; nv_save_o |-> gap_r >= SAVE_SPACING_CYCLES; endproperty
   a_gap: assert property (p_gap) else $error("saves too close");
   property p_data; $changed(nv_data_o) |-> nv_save_o; endproperty
   a_data: assert property (p_data) else $error("saved value moved without save");
   property p_range; $signed(pid_out_o) >= -16'sd10000 && $signed(pid_out_o) <= 16'sd10000; endproperty
   a_range: assert property (p_range) else $error("pid output out of range");
   property p_err; pslverr_o |-> psel_i && penable_i; endproperty
   a_err: assert property (p_err) else $error("error outside access phase");
   property p_route; out_cmd_o[0] == $past(pid_out_o) || out_cmd_o[0] == $past(manual_cmd_i[0]); endproperty
   a_route: assert property (p_route) else $error("output command from nowhere");
   property p_rst; $rose(reset_n_i) |-> pid_out_o == 16'h0000; endproperty
   a_rst: assert property (p_rst) else $error("pid output not clear after reset");
   property p_step; $changed(pid_out_o) |=> $stable(pid_out_o) [*8]; endproperty
   a_step: assert property (p_step) else $error("pid output steps too fast");
   c_save: cover property (nv_save_o);
   c_err: cover property (pslverr_o);
   c_step: cover property ($changed(pid_out_o));
endmodule
bind cvpid_core cvpid_core_sva #(.SAVE_SPACING_CYCLES(SAVE_SPACING_CYCLES)) i_sva (.clk_i(clk_i),
   .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i), .pslverr_o(pslverr_o), .manual_cmd_i(manual_cmd_i),
   .out_cmd_o(out_cmd_o), .nv_save_o(nv_save_o), .nv_data_o(nv_data_o), .pid_out_o(pid_out_o));
`default_nettype wire

// [control_variable_and_pid_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bench
// ----------------------------------------
module control_variable_and_pid_bench;
   logic clk_i = 0, reset_n_i = 0, psel = 0, penable = 0, pwrite = 0, set = 0, e;
   logic [7:0] paddr = 0, ra [8] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
   logic [3:0] idx = 0;
   logic [15:0] val = 0, nv_data_o, pid_out_o;
   logic [31:0] pwdata = 0, q, prdata_o;
   logic pready_o, pslverr_o, nv_save_o;
   logic [1:0][15:0] man = 0, out_cmd_o;
   cvpid_pkg::src_s [15:0] src;
   int errors = 0, n_compared = 0, saves = 0, t, f, d, k, a, b, x;
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) if (nv_save_o === 1'b1) saves++;
   cvpid_src_model i_src (.clk_i(clk_i), .set_i(set), .idx_i(idx), .val_i(val), .src_o(src));
   // short counts keep the run small: 10 cycles per ms, 50 cycles save spacing
   cvpid_core #(.CLK_PER_MS(10), .SAVE_SPACING_CYCLES(50)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .src_i(src), .manual_cmd_i(man), .out_cmd_o(out_cmd_o),
      .nv_save_o(nv_save_o), .nv_data_o(nv_data_o), .pid_out_o(pid_out_o));
   task test_done;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] w);
      n_compared++;
      if (g !== w) begin
         errors++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, g, w);
      end
   endtask
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] dd);
      @(posedge clk_i);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, dd};
      @(posedge clk_i);
      penable <= 1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready_o !== 1'b1 && k < 20);
      q = prdata_o;
      e = pslverr_o;
      {psel, penable} <= 2'b00;
      if (k >= 20) errors++;
      if (k >= 20) test_done();
   endtask
   task put(input logic [3:0] i, input int v);
      @(posedge clk_i);
      {set, idx, val} <= {1'b1, i, 16'(v)};
      @(posedge clk_i);
      set <= 0;
   endtask
   task wsave(input int n);
      for (k = 0; saves < n && k < 200; k++) @(posedge clk_i);
      if (k >= 200) errors++;
      if (k >= 200) test_done();
   endtask
   function automatic int cmp(int op, int p, int r);
      return op == 0 ? p == r : op == 1 ? p != r : op == 2 ? p > r : op == 3 ? p >= r : op == 4 ? p < r :
         op == 5 ? p <= r : p - r > 0;
   endfunction
   function automatic int pid(int prof, int tg, int fb);
      int er = prof == 2 ? fb - tg : tg - fb;
      if (er < 500 && er > -500) er = 0;
      if (er > 10000) er = 10000;
      if (er < (prof == 0 ? -10000 : 0)) er = prof == 0 ? -10000 : 0;
      return er;
   endfunction
   initial begin
      void'($urandom(55));
      man <= {16'($urandom), 16'($urandom)};
      repeat (4) @(posedge clk_i);
      reset_n_i <= 1;
      for (int i = 0; i < 8; i++) begin
         apb(0, ra[i], 0);
         chk(q, i == 3 ? 32'h0000000A : i == 5 ? 32'h00000100 : 32'h0);
      end
      apb(0, 8'h40, 0);
      chk({q[30:0], e}, 32'h1);
      apb(1, 8'h24, 32'h00001234);
      apb(0, 8'h24, 0);
      chk(q, 32'h0);
      $display("test registers done");
      d = $urandom % 65536;
      apb(1, 8'h04, d);
      apb(0, 8'h04, 0);
      chk(q, d);
      a = $urandom % 4;
      b = $urandom % 4;
      put(4, a);
      put(5, b);
      for (int op = 0; op < 7; op++) begin
         apb(1, 8'h00, {5'h00, 3'(op), 24'h121110});
         apb(0, 8'h08, 0);
         chk(32'(q[1]), cmp(op, a, b));
      end
      $display("test compare done");
      apb(1, 8'h00, 32'h02121110);
      put(5, 0);
      put(4, 0);
      d = $urandom % 30000;
      put(6, d);
      saves = 0;
      put(4, 1);
      wsave(1);
      chk(nv_data_o, 16'(d));
      put(6, d + 1);
      repeat (60) @(posedge clk_i);
      chk(saves, 1);
      put(4, 0);
      put(4, 1);
      wsave(2);
      chk(nv_data_o, 16'(d + 1));
      put(4, 0);
      put(4, 1);
      wsave(3);
      $display("test save done");
      apb(1, 8'h10, 1);
      apb(1, 8'h14, 500);
      for (int i = 0; i < 5; i++) begin
         t = $urandom % 9000;
         f = i == 4 ? t + 100 : $urandom % 10001;
         put(0, t);
         put(12, t);
         put(1, f);
         apb(1, 8'h0C, 32'h00140100 | (i % 4) << 16);
         repeat (600) @(posedge clk_i);
         x = pid(i % 4, t, f);
         chk(pid_out_o, x[15:0]);
         chk(out_cmd_o[0], x[15:0]);
         chk(out_cmd_o[1], man[1]);
         apb(0, 8'h24, 0);
         chk(q, 32'(x));
      end
      $display("test pid done");
      test_done();
   end
endmodule
`default_nettype wire
